// File: pbo_params.svh
`ifndef PBO_PARAMS_SVH
`define PBO_PARAMS_SVH
`define PBO_WIDTH 8
`define PBO_BIT_CAPT 0
`define PBO_BIT_TIMER1_COMPARE_A_OUTPUT 1
`define PBO_BIT_SS 2
`define PBO_BIT_MOSI 3
`define PBO_BIT_MISO 4
`define PBO_BIT_SCK 5
`define PBO_BIT_OSC_IN 6
`define PBO_BIT_OSC_OUT 7
`define PBO_RST_BYTE 8'h00
`endif

// File: pbo_periph_model.sv
module pbo_periph_model (
  input wire logic clk_i,
  input wire logic [5:0] drv_i,
  output logic [5:0] sig_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Peripheral outputs move just after the falling edge, as on-chip timer logic would.
  initial sig_o = 6'h00;
  always @(negedge clk_i) begin
    sig_o <= drv_i;
  end
endmodule

// File: pbo_pkg.sv
package pbo_pkg;
  typedef logic [7:0] pbo_byte_t;
endpackage

// File: pbo_port_b_override.sv
`include "pbo_params.svh"
// Notes on behaviour
// - SPI slave forces clock pin 5 to input; master leaves direction bit.
// - SPI master forces MISO pin 4 to input; slave uses direction bit.
// - SPI slave forces MOSI pin 3 to input; master uses direction bit.
// - SPI slave forces slave-select pin 2 to input.
// - Slave SPI active only while slave-select pin is low.
// - Forced-input SPI pins keep pull-up under their output bit; here the pull-up also needs the direction bit clear.
// - MISO carries master input and slave output; MOSI the reverse.
// - Pin 3 outputs OR of SPI master data and timer 2 compare.
// - Timer 2 compare reaches pin 3 only when direction is output.
// - Timer 1 compare B drives pin 2 when enabled and output, outside SPI slave mode, which forces pin 2 to input.
// - Timer 1 compare A drives pin 1 when enabled and output.
// - Compare pins also carry PWM waveforms of their timers.
// - Pin 0 feeds synchronized input to timer 1 capture.
// - Async timer 2 clock takes pin 7 as oscillator output.
// - Async timer 2 clock takes pin 6 as oscillator input.
// - Timer oscillator pins only with internal RC and async timer.
// - Pin 6 is clock pin for every non internal RC source.
// - Pin 7 clock use reads direction, output and input as zero.
// - Pin 6 clock use reads direction, output and input as zero.
// - Global pull-up disable switches every pull-up off.
// - Value override replaces output bit while driver is on.
module pbo_port_b_override (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic [7:0] DIR_BITS_I,
  input wire logic [7:0] OUT_BITS_I,
  input wire logic [7:0] PAD_IN_I,
  input wire logic GLOBAL_PULLUP_DISABLE_I,
  input wire logic SPI_ENABLE_BIT_I,
  input wire logic SPI_MASTER_SELECT_I,
  input wire logic SPI_SCK_OUT_I,
  input wire logic SPI_MASTER_DATA_OUT_I,
  input wire logic SPI_SLAVE_DATA_OUT_I,
  input wire logic TIMER2_COMPARE_OUTPUT_I,
  input wire logic TIMER2_COMPARE_ENABLE_I,
  input wire logic TIMER1_COMPARE_A_OUTPUT_I,
  input wire logic TIMER1_COMPARE_A_ENABLE_I,
  input wire logic TIMER1_COMPARE_B_OUTPUT_I,
  input wire logic TIMER1_COMPARE_B_ENABLE_I,
  input wire logic ASYNC_TIMER2_CLOCK_ENABLE_I,
  input wire logic INTERNAL_RC_SELECTED_I,
  input wire logic EXTERNAL_CLOCK_SELECTED_I,
  output logic [7:0] PAD_OUT_O,
  output logic [7:0] PAD_OE_O,
  output logic [7:0] PULLUP_EN_O,
  output logic [7:0] DIR_READ_O,
  output logic [7:0] OUT_READ_O,
  output logic [7:0] PIN_READ_O,
  output logic SPI_SCK_IN_O,
  output logic SPI_MASTER_DATA_IN_O,
  output logic SPI_SLAVE_DATA_IN_O,
  output logic SPI_SLAVE_ACTIVE_O,
  output logic TIMER1_CAPTURE_INPUT_O,
  output logic OSC_PINS_TIMER_O,
  output logic OSC_PIN6_CLOCK_O,
  output logic OSC_PIN7_CLOCK_O
);

  // ***********************************************************************
  // Input synchroniser
  // ***********************************************************************
  pbo_pkg::pbo_byte_t sync1_q, sync2_q, sync3_q, pin_q;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sync1_q <= `PBO_RST_BYTE;
      sync2_q <= `PBO_RST_BYTE;
      sync3_q <= `PBO_RST_BYTE;
      pin_q <= `PBO_RST_BYTE;
    end else if (CE_I) begin
      sync1_q <= PAD_IN_I;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      // A bit changes only once the second and third stages agree.
      pin_q <= (sync2_q & sync3_q) | (pin_q & (sync2_q | sync3_q));
    end
  end

  // ***********************************************************************
  // Override decode
  // ***********************************************************************
  wire spi_master = SPI_ENABLE_BIT_I & SPI_MASTER_SELECT_I;
  wire spi_slave = SPI_ENABLE_BIT_I & ~SPI_MASTER_SELECT_I;
  // Pin 6 is lost as I/O whenever the chip clock is not the internal RC.
  wire osc6_take = ~INTERNAL_RC_SELECTED_I | ASYNC_TIMER2_CLOCK_ENABLE_I;
  // Pin 7 stays usable with an external clock on pin 6.
  wire osc7_take = ASYNC_TIMER2_CLOCK_ENABLE_I |
                   (~INTERNAL_RC_SELECTED_I & ~EXTERNAL_CLOCK_SELECTED_I);
  wire timer_osc = INTERNAL_RC_SELECTED_I & ASYNC_TIMER2_CLOCK_ENABLE_I;

  pbo_pkg::pbo_byte_t force_in, pvo_en, pvo_val, clk_pin, oe_d, out_d, pu_d;

  // Forced-input pins.
  assign force_in = {osc7_take, osc6_take, spi_slave, spi_master, spi_slave, spi_slave,
                     1'b0, 1'b0};
  assign pvo_en = {2'b00, spi_master, spi_slave,
                   spi_master | TIMER2_COMPARE_ENABLE_I,
                   TIMER1_COMPARE_B_ENABLE_I, TIMER1_COMPARE_A_ENABLE_I, 1'b0};
  assign pvo_val = {2'b00, SPI_SCK_OUT_I, SPI_SLAVE_DATA_OUT_I,
                    SPI_MASTER_DATA_OUT_I | TIMER2_COMPARE_OUTPUT_I,
                    TIMER1_COMPARE_B_OUTPUT_I, TIMER1_COMPARE_A_OUTPUT_I, 1'b0};
  assign clk_pin = {osc7_take, osc6_take, 6'h00};

  // Compare outputs reach a pin only through its own direction bit.
  assign oe_d = DIR_BITS_I & ~force_in;
  assign out_d = (pvo_en & pvo_val) | (~pvo_en & OUT_BITS_I);
  // Forced SPI inputs keep the normal pull-up; clock pins have none.
  assign pu_d = ~DIR_BITS_I & OUT_BITS_I & ~clk_pin &
                {8{~GLOBAL_PULLUP_DISABLE_I}};

  // ***********************************************************************
  // Registered outputs
  // ***********************************************************************
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PAD_OUT_O <= `PBO_RST_BYTE;
      PAD_OE_O <= `PBO_RST_BYTE;
      PULLUP_EN_O <= `PBO_RST_BYTE;
      DIR_READ_O <= `PBO_RST_BYTE;
      OUT_READ_O <= `PBO_RST_BYTE;
      PIN_READ_O <= `PBO_RST_BYTE;
      SPI_SCK_IN_O <= 1'b0;
      SPI_MASTER_DATA_IN_O <= 1'b0;
      SPI_SLAVE_DATA_IN_O <= 1'b0;
      SPI_SLAVE_ACTIVE_O <= 1'b0;
      TIMER1_CAPTURE_INPUT_O <= 1'b0;
      OSC_PINS_TIMER_O <= 1'b0;
      OSC_PIN6_CLOCK_O <= 1'b0;
      OSC_PIN7_CLOCK_O <= 1'b0;
    end else if (CE_I) begin
      PAD_OUT_O <= out_d & oe_d;
      PAD_OE_O <= oe_d;
      PULLUP_EN_O <= pu_d;
      DIR_READ_O <= DIR_BITS_I & ~clk_pin;
      OUT_READ_O <= OUT_BITS_I & ~clk_pin;
      PIN_READ_O <= pin_q & ~clk_pin;
      SPI_SCK_IN_O <= pin_q[`PBO_BIT_SCK];
      SPI_MASTER_DATA_IN_O <= pin_q[`PBO_BIT_MISO];
      SPI_SLAVE_DATA_IN_O <= pin_q[`PBO_BIT_MOSI];
      SPI_SLAVE_ACTIVE_O <= spi_slave & ~pin_q[`PBO_BIT_SS];
      TIMER1_CAPTURE_INPUT_O <= pin_q[`PBO_BIT_CAPT];
      OSC_PINS_TIMER_O <= timer_osc;
      OSC_PIN6_CLOCK_O <= osc6_take;
      OSC_PIN7_CLOCK_O <= osc7_take;
    end
  end

  // ***********************************************************************
  // Assertions
  // ***********************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_slave_sck_input: assert property (CE_I && spi_slave |=> !PAD_OE_O[5])
    else $error("sck pin driven in slave mode");
  a_master_miso_input: assert property (CE_I && spi_master |=> !PAD_OE_O[4])
    else $error("miso pin driven in master mode");
  a_slave_mosi_input: assert property (CE_I && spi_slave |=> !PAD_OE_O[3])
    else $error("mosi pin driven in slave mode");
  a_slave_ss_input: assert property (CE_I && spi_slave |=> !PAD_OE_O[2])
    else $error("ss pin driven in slave mode");
  a_slave_active_ss: assert property (SPI_SLAVE_ACTIVE_O |-> !$past(pin_q[2]))
    else $error("slave active with ss high");
  a_pullup_off_global: assert property (CE_I && GLOBAL_PULLUP_DISABLE_I
                                        |=> PULLUP_EN_O == 8'h00)
    else $error("pull-up on while globally disabled");
  a_timer1_compare_a_output_value: assert property (CE_I && TIMER1_COMPARE_A_ENABLE_I && DIR_BITS_I[1]
                                 |=> PAD_OUT_O[1] == $past(TIMER1_COMPARE_A_OUTPUT_I))
    else $error("compare a not on pin 1");
  a_oc2_or_value: assert property (CE_I && TIMER2_COMPARE_ENABLE_I && DIR_BITS_I[3] && !spi_slave
                                   |=> PAD_OUT_O[3] == $past(TIMER2_COMPARE_OUTPUT_I |
                                   (spi_master & SPI_MASTER_DATA_OUT_I)))
    else $error("pin 3 value wrong");
  a_clk_pin_zero: assert property (CE_I && osc6_take |=> DIR_READ_O[6] == 1'b0 &&
                                   PIN_READ_O[6] == 1'b0)
    else $error("pin 6 reads nonzero as clock pin");

  // ***********************************************************************
  // Direction hand-back in the other SPI mode
  // ***********************************************************************
  // A force that stays stuck would pass every forcing check above.
  // These checks catch it by watching the pin in the mode that leaves it to the port.
  a_master_sck_dir: assert property (CE_I && spi_master
                                     |=> PAD_OE_O[5] == $past(DIR_BITS_I[5]))
    else $error("sck direction ignored in master mode");
  a_slave_miso_dir: assert property (CE_I && spi_slave
                                     |=> PAD_OE_O[4] == $past(DIR_BITS_I[4]))
    else $error("miso direction ignored in slave mode");
  a_master_mosi_dir: assert property (CE_I && spi_master
                                      |=> PAD_OE_O[3] == $past(DIR_BITS_I[3]))
    else $error("mosi direction ignored in master mode");
  a_master_ss_dir: assert property (CE_I && spi_master
                                    |=> PAD_OE_O[2] == $past(DIR_BITS_I[2]))
    else $error("ss direction ignored in master mode");

  // ***********************************************************************
  // Synchronised input paths
  // ***********************************************************************
  // A pad level held for five enabled edges has crossed all three flops and the filter.
  // A shorter pulse may be swallowed, which is the point of the filter.
  sequence s_cap_high_held;
    (CE_I && PAD_IN_I[0]) [*5];
  endsequence
  sequence s_cap_low_held;
    (CE_I && !PAD_IN_I[0]) [*5];
  endsequence
  sequence s_ss_low_held;
    (CE_I && spi_slave && !PAD_IN_I[2]) [*5];
  endsequence
  a_capture_rise: assert property (s_cap_high_held |=> TIMER1_CAPTURE_INPUT_O)
    else $error("capture input missed a high level");
  a_capture_fall: assert property (s_cap_low_held |=> !TIMER1_CAPTURE_INPUT_O)
    else $error("capture input missed a low level");
  a_slave_active_low: assert property (s_ss_low_held |=> SPI_SLAVE_ACTIVE_O)
    else $error("slave not active with ss held low");
  a_slave_active_path: assert property (CE_I && spi_slave && !pin_q[2]
                                        |=> SPI_SLAVE_ACTIVE_O)
    else $error("slave not active after ss low");
  a_mosi_slave_in: assert property (CE_I
                                    |=> SPI_SLAVE_DATA_IN_O == $past(pin_q[3]))
    else $error("slave data input not from pin 3");
  a_miso_master_in: assert property (CE_I
                                     |=> SPI_MASTER_DATA_IN_O == $past(pin_q[4]))
    else $error("master data input not from pin 4");
  a_capture_path: assert property (CE_I
                                   |=> TIMER1_CAPTURE_INPUT_O == $past(pin_q[0]))
    else $error("capture input not from pin 0");
  a_sck_in_path: assert property (CE_I
                                  |=> SPI_SCK_IN_O == $past(pin_q[5]))
    else $error("sck input not from pin 5");

  // ***********************************************************************
  // Pull-ups and pad values
  // ***********************************************************************
  // Value checks other than a_pin0_plain are gated by the direction bit, since an undriven pad reads as zero.
  // That keeps an idle pad from ever showing a stale override value.
  a_forced_pullup: assert property (CE_I && spi_slave && !GLOBAL_PULLUP_DISABLE_I &&
                                    !DIR_BITS_I[5] && OUT_BITS_I[5]
                                    |=> PULLUP_EN_O[5])
    else $error("forced sck input lost its pull-up");
  a_miso_slave_value: assert property (CE_I && spi_slave && DIR_BITS_I[4]
                                       |=> PAD_OUT_O[4] == $past(SPI_SLAVE_DATA_OUT_I))
    else $error("slave data not on pin 4");
  a_oc2_needs_dir: assert property (CE_I && !DIR_BITS_I[3]
                                    |=> !PAD_OE_O[3] && !PAD_OUT_O[3])
    else $error("pin 3 driven without direction bit");
  a_timer1_compare_b_output_value: assert property (CE_I && TIMER1_COMPARE_B_ENABLE_I && DIR_BITS_I[2] && !spi_slave
                                 |=> PAD_OUT_O[2] == $past(TIMER1_COMPARE_B_OUTPUT_I))
    else $error("compare b not on pin 2");
  a_timer1_compare_a_output_needs_dir: assert property (CE_I && !DIR_BITS_I[1] |=> !PAD_OE_O[1])
    else $error("pin 1 driven without direction bit");
  a_port_value_pin1: assert property (CE_I && !TIMER1_COMPARE_A_ENABLE_I && DIR_BITS_I[1]
                                      |=> PAD_OUT_O[1] == $past(OUT_BITS_I[1]))
    else $error("pin 1 ignores its output bit");
  a_pin0_plain: assert property (CE_I |=> PAD_OE_O[0] == $past(DIR_BITS_I[0]) &&
                                 PAD_OUT_O[0] == $past(DIR_BITS_I[0] & OUT_BITS_I[0]) &&
                                 PULLUP_EN_O[0] == $past(!DIR_BITS_I[0] && OUT_BITS_I[0] &&
                                 !GLOBAL_PULLUP_DISABLE_I))
    else $error("pin 0 overridden");
  a_master_sck_value: assert property (CE_I && spi_master && DIR_BITS_I[5]
                                       |=> PAD_OUT_O[5] == $past(SPI_SCK_OUT_I))
    else $error("master clock not on pin 5");

  // ***********************************************************************
  // Oscillator pins
  // ***********************************************************************
  // Once a pin carries a clock, any port drive would fight the crystal.
  // Drive and, on pin 6, pull-up are therefore checked off, not only the readback.
  a_async_pin7: assert property (CE_I && ASYNC_TIMER2_CLOCK_ENABLE_I
                                 |=> OSC_PIN7_CLOCK_O && !PAD_OE_O[7])
    else $error("pin 7 not taken by async timer");
  a_async_pin6: assert property (CE_I && ASYNC_TIMER2_CLOCK_ENABLE_I
                                 |=> OSC_PIN6_CLOCK_O && !PAD_OE_O[6])
    else $error("pin 6 not taken by async timer");
  a_timer_osc_pins: assert property (CE_I |=> OSC_PINS_TIMER_O ==
                                     $past(INTERNAL_RC_SELECTED_I && ASYNC_TIMER2_CLOCK_ENABLE_I))
    else $error("timer oscillator pins flag wrong");
  a_pin6_ext_clock: assert property (CE_I && !INTERNAL_RC_SELECTED_I
                                     |=> OSC_PIN6_CLOCK_O && !PULLUP_EN_O[6])
    else $error("pin 6 not a clock pin");
  a_pin7_read_zero: assert property (CE_I && osc7_take
                                     |=> !DIR_READ_O[7] && !OUT_READ_O[7] &&
                                     !PIN_READ_O[7])
    else $error("pin 7 reads nonzero as clock pin");
  a_pin6_out_zero: assert property (CE_I && osc6_take |=> !OUT_READ_O[6])
    else $error("pin 6 output bit reads nonzero");

  // ***********************************************************************
  // Mode changes and clock enable
  // ***********************************************************************
  // The force must land on the first edge after the enable rises, with no extra stage.
  // A frozen block must hold every pad output, or pins would glitch while stopped.
  a_mode_same_cycle: assert property (CE_I && $rose(SPI_ENABLE_BIT_I) && !SPI_MASTER_SELECT_I
                                      |=> !PAD_OE_O[3] && !PAD_OE_O[5])
    else $error("slave force late after enable");
  a_freeze_ce: assert property (!CE_I |=> $stable(PAD_OE_O) && $stable(PAD_OUT_O) &&
                                $stable(PULLUP_EN_O))
    else $error("outputs moved while clock enable low");
endmodule

// File: tb_pbo_port_b_override.sv
module tb_pbo_port_b_override;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, global_pullup_disable, spi_enable_bit, mst, t2e, tae, tbe, as2, irc, external_clock_selected;
  logic sact, sdi, cap, otm, c6, c7, ce, sck, mdi;
  logic [7:0] dir, outb, pad, oe, po, pu, dr, ord, prd;
  logic [5:0] drv, sig;
  int n_fail, tests_run, cyc;
  pbo_periph_model per_u (.clk_i(clk), .drv_i(drv), .sig_o(sig));
  pbo_port_b_override dut_u (.CLK_I(clk), .RST_I(rst), .CE_I(ce), .DIR_BITS_I(dir),
    .OUT_BITS_I(outb), .PAD_IN_I(pad), .GLOBAL_PULLUP_DISABLE_I(global_pullup_disable), .SPI_ENABLE_BIT_I(spi_enable_bit),
    .SPI_MASTER_SELECT_I(mst), .SPI_SCK_OUT_I(sig[0]), .SPI_MASTER_DATA_OUT_I(sig[1]),
    .SPI_SLAVE_DATA_OUT_I(sig[2]), .TIMER2_COMPARE_OUTPUT_I(sig[3]),
    .TIMER2_COMPARE_ENABLE_I(t2e), .TIMER1_COMPARE_A_OUTPUT_I(sig[4]),
    .TIMER1_COMPARE_A_ENABLE_I(tae), .TIMER1_COMPARE_B_OUTPUT_I(sig[5]),
    .TIMER1_COMPARE_B_ENABLE_I(tbe), .ASYNC_TIMER2_CLOCK_ENABLE_I(as2),
    .INTERNAL_RC_SELECTED_I(irc), .EXTERNAL_CLOCK_SELECTED_I(external_clock_selected), .PAD_OUT_O(po),
    .PAD_OE_O(oe), .PULLUP_EN_O(pu), .DIR_READ_O(dr), .OUT_READ_O(ord), .PIN_READ_O(prd),
    .SPI_SCK_IN_O(sck), .SPI_MASTER_DATA_IN_O(mdi), .SPI_SLAVE_DATA_IN_O(sdi),
    .SPI_SLAVE_ACTIVE_O(sact), .TIMER1_CAPTURE_INPUT_O(cap), .OSC_PINS_TIMER_O(otm),
    .OSC_PIN6_CLOCK_O(c6), .OSC_PIN7_CLOCK_O(c7));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Pad-derived outputs need five falling edges: three sync flops, filter and output.
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic t_slave;
    spi_enable_bit = 1; mst = 0; dir = 8'h13; outb = 8'h3C; pad = 8'h09; drv = 6'h04;
    wt(6);
    chk("oe", 8'h13, oe);
    chk("pullup", 8'h2C, pu);
    chk("pad_out", 8'h10, po);
    chk("spi_in", 8'h07, {5'h00, sact, sdi, cap});
    pad = 8'h0D;
    wt(6);
    chk("ss_high", 8'h00, {7'h00, sact});
    $display("slave test done");
  endtask
  task automatic t_master;
    mst = 1; dir = 8'h3C; outb = 8'h00; drv = 6'h03; pad = 8'h30;
    wt(6);
    chk("oe", 8'h2C, oe);
    chk("pad_out", 8'h28, po);
    chk("spi_master_in", 8'h06, {5'h00, sck, mdi, sact});
    $display("master test done");
  endtask
  task automatic t_timer;
    spi_enable_bit = 0; dir = 8'h0E; t2e = 1; tae = 1; tbe = 1; drv = 6'h18;
    wt(3);
    chk("oe", 8'h0E, oe);
    chk("pad_out", 8'h0A, po);
    dir = 8'h00; outb = 8'hFF; global_pullup_disable = 1;
    wt(3);
    chk("oe_in", 8'h00, oe);
    chk("pullup_off", 8'h00, pu);
    global_pullup_disable = 0;
    wt(3);
    chk("pullup_on", 8'hFF, pu);
    $display("timer test done");
  endtask
  task automatic t_clock;
    t2e = 0; tae = 0; tbe = 0; dir = 8'hFF; as2 = 1; pad = 8'hFF;
    wt(6);
    chk("osc", 8'h07, {5'h00, otm, c7, c6});
    chk("dir_read", 8'h3F, dr);
    chk("out_read", 8'h3F, ord);
    chk("pin_read", 8'h3F, prd);
    irc = 0; external_clock_selected = 1; as2 = 0;
    wt(3);
    chk("osc_ext", 8'h01, {5'h00, otm, c7, c6});
    chk("dir_read", 8'hBF, dr);
    chk("out_read", 8'hBF, ord);
    chk("pin_read", 8'hBF, prd);
    ce = 0; dir = 8'h00;
    wt(3);
    chk("ce_hold", 8'hBF, dr);
    ce = 1;
    $display("clock test done");
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 400) begin
      n_fail++;
      test_done;
    end
  end
  initial begin
    n_fail = 0; tests_run = 0; cyc = 0; rst = 1; dir = 8'h00; outb = 8'h00; pad = 8'h00;
    global_pullup_disable = 0; spi_enable_bit = 0; mst = 0; t2e = 0; tae = 0; tbe = 0; as2 = 0; irc = 1; external_clock_selected = 0;
    drv = 6'h00; ce = 1;
    wt(5);
    rst = 0;
    t_slave;
    t_master;
    t_timer;
    t_clock;
    test_done;
  end
endmodule
